// ---- design/coax_mau_defines.svh ----
// offsets, field positions, reset values and timing counts of the coax attachment control logic
// How it works
// - Manchester data from the station's transmit pair is passed through to the coax transmit output.
// - Transmit input pulses shorter than 15 ns or below the 225 mV squelch level never reach the coax driver.
// - The transmitter turns off at packet end once the input stays below squelch for more than 190 ns.
// - Data received from the coax is forwarded to the station on the receive output pair.
// - The receive path stays inactive while the coax DC level is below the receive squelch threshold.
// - A coax level beyond the collision threshold is signalled as 10 MHz on the collision pair.
// - The lower receive threshold applies while idle, the larger transmit threshold while transmitting.
// - Heartbeat is enabled with the strap grounded and disabled with it tied to the negative supply.
// - With heartbeat enabled, 10 MHz is sent on the collision pair for 10 bit times after each packet that ends below squelch, not after jabber.
// - A transmission longer than the jabber limit disables the transmitter and signals 10 MHz on the pair.
// - The jabber state is left only after the transmit input stays idle for 500 ms.
// - The station interface stays powered down while the coax input is unterminated.
// - When the coax input becomes unterminated after power-up, 10 MHz is sent for 800 ms, then the port is off.
`ifndef COAX_MAU_DEFINES_SVH
`define COAX_MAU_DEFINES_SVH

`define CLK_PERIOD_NS    25
`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define REG_INT_STATUS   8'h08
`define REG_INT_MASK     8'h0c

`define CTRL_TX_ALLOW    0
`define CTRL_RX_ALLOW    1
`define CTRL_HB_ALLOW    2
`define CTRL_RESET       3'h7
`define CTRL_WIDTH       3

`define STAT_TX_ON       0
`define STAT_JABBER      1
`define STAT_RX_ACTIVE   2
`define STAT_COLLISION   3
`define STAT_HEARTBEAT   4
`define STAT_AUI_UP      5
`define STAT_ISOLATING   6
`define STAT_HB_STRAP    7
`define STAT_WIDTH       8

`define INT_WIDTH        6
`define INT_MASK_RESET   6'h00

`define T_MIN_PULSE_NS   15
`define T_TX_OFF_NS      190
`define T_BIT_NS         100
`define HB_BITS          10
`define T_HB_DELAY_NS    1100
`define T_JABBER_MS      26
`define T_JAB_IDLE_MS    500
`define T_ISOLATE_MS     800
`define NS_PER_MS        1000000

`define MIN_PULSE_CYC    ((`T_MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TX_OFF_CYC       ((`T_TX_OFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HB_WIDTH_CYC     ((`HB_BITS * `T_BIT_NS) / `CLK_PERIOD_NS)
`define HB_DELAY_CYC     ((`T_HB_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define JABBER_CYC       ((`T_JABBER_MS * `NS_PER_MS) / `CLK_PERIOD_NS)
`define JAB_IDLE_CYC     ((`T_JAB_IDLE_MS * `NS_PER_MS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ISOLATE_CYC      ((`T_ISOLATE_MS * `NS_PER_MS) / `CLK_PERIOD_NS)

`endif

// ---- design/coax_mau_pkg.sv ----
// types shared by the coax attachment control logic
package coax_mau_pkg;

  typedef struct packed {
    logic heartbeat_strap;
    logic rx_terminated;
    logic coll_tx_cmp;
    logic coll_rx_cmp;
    logic rx_dc_above;
    logic coax_receive_in;
    logic tx_squelch_ok;
    logic tx_data;
  } pin_in_t;

  typedef struct packed {
    logic terminated;
    logic unterminated;
    logic hb_done;
    logic jab_exit;
    logic jab_enter;
    logic coll_start;
  } event_t;

  typedef enum logic [1:0] {
    TX_IDLE   = 2'b00,
    TX_ACTIVE = 2'b01,
    TX_JABBER = 2'b10
  } tx_state_t;

  typedef enum logic [1:0] {
    HB_IDLE = 2'b00,
    HB_WAIT = 2'b01,
    HB_SEND = 2'b10
  } hb_state_t;

  typedef enum logic [1:0] {
    AUI_DOWN   = 2'b00,
    AUI_UP     = 2'b01,
    AUI_SIGNAL = 2'b10
  } aui_state_t;

endpackage : coax_mau_pkg

// ---- design/pin_synchronizer.sv ----
// three-stage synchroniser; output follows once stages two and three agree
`timescale 1ns/100ps
module pin_synchronizer #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,    // block clock
  input  wire logic             rst_n,  // synchronised reset
  input  wire logic [WIDTH-1:0] d,      // asynchronous inputs
  output logic      [WIDTH-1:0] q       // settled copy
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  if (WIDTH < 1) $error("pin_synchronizer: WIDTH must be at least 1");

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2[i] == s3[i]) begin
          q[i] <= s3[i];
        end
      end
    end
  end
endmodule : pin_synchronizer

// ---- design/interval_timer.sv ----
// counts cycles while run is high; done once limit cycles have passed
`timescale 1ns/100ps
module interval_timer #(
  parameter int WIDTH = 26
) (
  input  wire logic             clk,    // block clock
  input  wire logic             rst_n,  // synchronised reset
  input  wire logic             run,    // count while high, clear when low
  input  wire logic [WIDTH-1:0] limit,  // cycles to reach
  output logic                  done    // high once limit reached
);
  logic [WIDTH-1:0] cnt;

  if (WIDTH < 2) $error("interval_timer: WIDTH must be at least 2");

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (!run) begin
      cnt <= '0;
    end else if (cnt < limit) begin
      cnt <= cnt + 1'b1;
    end
  end

  assign done = run && (cnt >= limit);
endmodule : interval_timer

// ---- design/coax_mau_control_logic.sv ----
// control logic of the coax attachment unit with its AHB-Lite register slave
//
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "coax_mau_defines.svh"
module coax_mau_control_logic
  import coax_mau_pkg::*;
#(
  parameter int TW          = 26,             // width of long timers
  parameter int JABBER_CYC  = `JABBER_CYC,    // jabber activation limit
  parameter int JAB_IDLE_CYC = `JAB_IDLE_CYC, // idle time to leave jabber
  parameter int ISOLATE_CYC = `ISOLATE_CYC    // isolation signalling time
) (
  input  wire logic        CLOCK,              // 40 MHz clock
  input  wire logic        RSTN,               // asynchronous reset, active low
  input  wire logic        HSEL,               // slave select
  input  wire logic [31:0] HADDR,              // byte address
  input  wire logic [1:0]  HTRANS,             // transfer type
  input  wire logic        HWRITE,             // write when high
  input  wire logic [2:0]  HSIZE,              // transfer size, word only
  input  wire logic [31:0] HWDATA,             // write data
  input  wire logic        HREADY,             // bus ready
  output logic      [31:0] HRDATA,             // read data
  output logic             HREADYOUT,          // slave ready
  output logic             HRESP,              // always okay
  input  wire logic        TX_DATA,            // station transmit data
  input  wire logic        TX_SQUELCH_OK,      // transmit amplitude above squelch
  input  wire logic        COAX_RECEIVE_IN,    // data received from coax
  input  wire logic        RX_DC_ABOVE,        // coax DC level above receive squelch
  input  wire logic        COLL_RX_CMP,        // coax beyond receive collision threshold
  input  wire logic        COLL_TX_CMP,        // coax beyond transmit collision threshold
  input  wire logic        RX_TERMINATED,      // terminated segment seen
  input  wire logic        HEARTBEAT_STRAP,    // high when strap grounded
  output logic             COAX_TRANSMIT_OUT,  // data to coax driver
  output logic             TX_DRIVER_ON,       // coax driver enabled
  output logic             RX_OUT,             // receive data to station
  output logic             RX_ACTIVE,          // receive path active
  output logic             COLLISION_OUT_PAIR, // 10 MHz collision signal
  output logic             AUI_POWERED,        // station interface powered
  output logic             IRQ                 // level interrupt
);
  if (TW < 2 || TW > 31) $error("coax_mau_control_logic: TW out of range");
  if (JABBER_CYC < 2 || JABBER_CYC >= (1 << TW)) $error("coax_mau_control_logic: bad JABBER_CYC");
  if (JAB_IDLE_CYC < 2 || JAB_IDLE_CYC >= (1 << TW)) $error("coax_mau_control_logic: bad JAB_IDLE_CYC");
  if (ISOLATE_CYC < 2 || ISOLATE_CYC >= (1 << TW)) $error("coax_mau_control_logic: bad ISOLATE_CYC");

  localparam logic [TW-1:0] LIM_TX_OFF   = TW'(`TX_OFF_CYC);
  localparam logic [TW-1:0] LIM_HB_DELAY = TW'(`HB_DELAY_CYC);
  localparam logic [TW-1:0] LIM_HB_WIDTH = TW'(`HB_WIDTH_CYC);
  localparam logic [TW-1:0] LIM_JABBER   = TW'(JABBER_CYC);
  localparam logic [TW-1:0] LIM_IDLE     = TW'(JAB_IDLE_CYC);
  localparam logic [TW-1:0] LIM_ISOLATE  = TW'(ISOLATE_CYC);
  localparam logic [1:0]    MIN_PULSE    = 2'(`MIN_PULSE_CYC);

  // reset release
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // pin inputs
  pin_in_t pin_raw;
  pin_in_t pin;

  assign pin_raw = '{heartbeat_strap: HEARTBEAT_STRAP, rx_terminated: RX_TERMINATED,
                     coll_tx_cmp: COLL_TX_CMP, coll_rx_cmp: COLL_RX_CMP,
                     rx_dc_above: RX_DC_ABOVE, coax_receive_in: COAX_RECEIVE_IN,
                     tx_squelch_ok: TX_SQUELCH_OK, tx_data: TX_DATA};

  pin_synchronizer #(.WIDTH($bits(pin_in_t))) u_sync (
    .clk   (CLOCK),
    .rst_n (rst_n),
    .d     (pin_raw),
    .q     (pin)
  );

  // state
  tx_state_t            tx_state;
  hb_state_t            hb_state;
  aui_state_t           aui_state;
  logic [`CTRL_WIDTH-1:0] ctrl;
  logic [`INT_WIDTH-1:0]  int_status;
  logic [`INT_WIDTH-1:0]  int_mask;
  logic [1:0]           pulse_cnt;
  logic [1:0]           osc_cnt;
  logic                 coll_seen;
  logic                 hb_strap;

  logic tx_off_done;
  logic jabber_done;
  logic idle_done;
  logic hb_delay_done;
  logic hb_width_done;
  logic isolate_done;

  logic   aui_up;
  logic   hb_enabled;
  logic   pulse_ok;
  logic   collision;
  logic   coll_request;
  event_t ev;

  assign aui_up     = (aui_state == AUI_UP);
  assign hb_enabled = hb_strap && ctrl[`CTRL_HB_ALLOW];
  assign pulse_ok   = pin.tx_squelch_ok && (pulse_cnt >= MIN_PULSE);
  assign collision  = aui_up && ((tx_state == TX_ACTIVE) ? pin.coll_tx_cmp
                                                          : pin.coll_rx_cmp);
  assign coll_request = collision || (tx_state == TX_JABBER) || (hb_state == HB_SEND)
                        || (aui_state == AUI_SIGNAL);

  // strap registered every cycle after reset release
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      hb_strap <= 1'b0;
    end else begin
      hb_strap <= pin.heartbeat_strap;
    end
  end

  // timers
  interval_timer #(.WIDTH(TW)) u_tx_off (
    .clk   (CLOCK),
    .rst_n (rst_n),
    .run   ((tx_state == TX_ACTIVE) && !pin.tx_squelch_ok),
    .limit (LIM_TX_OFF),
    .done  (tx_off_done)
  );

  interval_timer #(.WIDTH(TW)) u_jabber (
    .clk   (CLOCK),
    .rst_n (rst_n),
    .run   (tx_state == TX_ACTIVE),
    .limit (LIM_JABBER),
    .done  (jabber_done)
  );

  interval_timer #(.WIDTH(TW)) u_idle (
    .clk   (CLOCK),
    .rst_n (rst_n),
    .run   ((tx_state == TX_JABBER) && !pin.tx_squelch_ok),
    .limit (LIM_IDLE),
    .done  (idle_done)
  );

  interval_timer #(.WIDTH(TW)) u_hb_delay (
    .clk   (CLOCK),
    .rst_n (rst_n),
    .run   (hb_state == HB_WAIT),
    .limit (LIM_HB_DELAY),
    .done  (hb_delay_done)
  );

  interval_timer #(.WIDTH(TW)) u_hb_width (
    .clk   (CLOCK),
    .rst_n (rst_n),
    .run   (hb_state == HB_SEND),
    .limit (LIM_HB_WIDTH),
    .done  (hb_width_done)
  );

  interval_timer #(.WIDTH(TW)) u_isolate (
    .clk   (CLOCK),
    .rst_n (rst_n),
    .run   (aui_state == AUI_SIGNAL),
    .limit (LIM_ISOLATE),
    .done  (isolate_done)
  );

  // width of the current above-squelch pulse
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      pulse_cnt <= 2'h0;
    end else if (!pin.tx_squelch_ok) begin
      pulse_cnt <= 2'h0;
    end else if (pulse_cnt != 2'h3) begin
      pulse_cnt <= pulse_cnt + 2'h1;
    end
  end

  // transmit and jabber
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      tx_state <= TX_IDLE;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          if (pulse_ok && aui_up && ctrl[`CTRL_TX_ALLOW]) begin
            tx_state <= TX_ACTIVE;
          end
        end
        TX_ACTIVE: begin
          if (jabber_done) begin
            tx_state <= TX_JABBER;
          end else if (tx_off_done || !ctrl[`CTRL_TX_ALLOW] || !aui_up) begin
            tx_state <= TX_IDLE;
          end
        end
        TX_JABBER: begin
          if (idle_done) begin
            tx_state <= TX_IDLE;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // heartbeat after each normal packet end
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      hb_state <= HB_IDLE;
    end else begin
      case (hb_state)
        HB_IDLE: begin
          if (tx_state == TX_ACTIVE && tx_off_done && !jabber_done && hb_enabled) begin
            hb_state <= HB_WAIT;
          end
        end
        HB_WAIT: begin
          if (hb_delay_done) begin
            hb_state <= HB_SEND;
          end
        end
        HB_SEND: begin
          if (hb_width_done) begin
            hb_state <= HB_IDLE;
          end
        end
        default: hb_state <= HB_IDLE;
      endcase
    end
  end

  // station interface power and isolation
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      aui_state <= AUI_DOWN;
    end else begin
      case (aui_state)
        AUI_DOWN: begin
          if (pin.rx_terminated) begin
            aui_state <= AUI_UP;
          end
        end
        AUI_UP: begin
          if (!pin.rx_terminated) begin
            aui_state <= AUI_SIGNAL;
          end
        end
        AUI_SIGNAL: begin
          if (pin.rx_terminated) begin
            aui_state <= AUI_UP;
          end else if (isolate_done) begin
            aui_state <= AUI_DOWN;
          end
        end
        default: aui_state <= AUI_DOWN;
      endcase
    end
  end

  // 10 MHz from the 40 MHz clock
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt <= 2'h0;
    end else begin
      osc_cnt <= osc_cnt + 2'h1;
    end
  end

  // line outputs
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      COAX_TRANSMIT_OUT <= 1'b0;
      TX_DRIVER_ON      <= 1'b0;
    end else begin
      TX_DRIVER_ON      <= (tx_state == TX_ACTIVE);
      COAX_TRANSMIT_OUT <= (tx_state == TX_ACTIVE) && pin.tx_squelch_ok
                           && pin.tx_data;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      RX_ACTIVE <= 1'b0;
      RX_OUT    <= 1'b0;
    end else begin
      RX_ACTIVE <= aui_up && ctrl[`CTRL_RX_ALLOW] && pin.rx_dc_above;
      RX_OUT    <= aui_up && ctrl[`CTRL_RX_ALLOW] && pin.rx_dc_above
                   && pin.coax_receive_in;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      COLLISION_OUT_PAIR <= 1'b0;
      AUI_POWERED        <= 1'b0;
    end else begin
      COLLISION_OUT_PAIR <= coll_request && osc_cnt[1];
      AUI_POWERED        <= aui_up;
    end
  end

  // events
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      coll_seen <= 1'b0;
    end else begin
      coll_seen <= collision;
    end
  end

  assign ev.coll_start   = collision && !coll_seen;
  assign ev.jab_enter    = (tx_state == TX_ACTIVE) && jabber_done;
  assign ev.jab_exit     = (tx_state == TX_JABBER) && idle_done;
  assign ev.hb_done      = (hb_state == HB_SEND) && hb_width_done;
  assign ev.unterminated = aui_up && !pin.rx_terminated;
  assign ev.terminated   = (aui_state != AUI_UP) && pin.rx_terminated;

  // bus slave
  logic       wr_pend;
  logic [7:0] wr_addr;
  logic       addr_ok;
  logic       wr_now;
  logic [31:0] rd_value;

  assign addr_ok = HSEL && HTRANS[1] && HREADY;
  assign wr_now  = wr_pend;

  always_comb begin
    rd_value = 32'h0;
    case (HADDR[7:0])
      `REG_CTRL:       rd_value[`CTRL_WIDTH-1:0] = ctrl;
      `REG_STATUS: begin
        rd_value[`STAT_TX_ON]     = (tx_state == TX_ACTIVE);
        rd_value[`STAT_JABBER]    = (tx_state == TX_JABBER);
        rd_value[`STAT_RX_ACTIVE] = RX_ACTIVE;
        rd_value[`STAT_COLLISION] = collision;
        rd_value[`STAT_HEARTBEAT] = (hb_state == HB_SEND);
        rd_value[`STAT_AUI_UP]    = aui_up;
        rd_value[`STAT_ISOLATING] = (aui_state == AUI_SIGNAL);
        rd_value[`STAT_HB_STRAP]  = hb_strap;
      end
      `REG_INT_STATUS: rd_value[`INT_WIDTH-1:0] = int_status;
      `REG_INT_MASK:   rd_value[`INT_WIDTH-1:0] = int_mask;
      default:         rd_value = 32'h0;
    endcase
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= addr_ok && HWRITE;
      if (addr_ok) begin
        wr_addr <= HADDR[7:0];
      end
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      HRDATA    <= 32'h0;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      if (addr_ok && !HWRITE) begin
        HRDATA <= rd_value;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl     <= `CTRL_RESET;
      int_mask <= `INT_MASK_RESET;
    end else if (wr_now) begin
      if (wr_addr == `REG_CTRL) begin
        ctrl <= HWDATA[`CTRL_WIDTH-1:0];
      end
      if (wr_addr == `REG_INT_MASK) begin
        int_mask <= HWDATA[`INT_WIDTH-1:0];
      end
    end
  end

  // sticky events, write one to clear, a new event wins
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      int_status <= '0;
    end else begin
      int_status <= (int_status & ~((wr_now && wr_addr == `REG_INT_STATUS) ?
                                    HWDATA[`INT_WIDTH-1:0] : `INT_WIDTH'h0)) | ev;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(int_status & int_mask);
    end
  end
endmodule : coax_mau_control_logic

// ---- bench/coax_mau_checker.sv ----
// pin assertions for the coax attachment control logic
`timescale 1ns/100ps
module coax_mau_checker #(
  parameter int JABBER_CYC = 200  // jabber limit in cycles
) (
  input wire logic CLOCK,              // clock
  input wire logic RSTN,               // reset, low
  input wire logic TX_SQUELCH_OK,      // squelch open
  input wire logic COAX_TRANSMIT_OUT,  // coax data
  input wire logic TX_DRIVER_ON,       // driver on
  input wire logic RX_DC_ABOVE,        // receive level
  input wire logic RX_ACTIVE,          // receive active
  input wire logic RX_TERMINATED,      // segment seen
  input wire logic AUI_POWERED,        // station side up
  input wire logic COLLISION_OUT_PAIR  // collision wave
);
  int on_run;
  // length of the current unbroken driver-on stretch
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) on_run <= 0;
    else on_run <= TX_DRIVER_ON ? on_run + 1 : 0;
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  squelch_out_a: assert property (!TX_SQUELCH_OK [*6] |-> !COAX_TRANSMIT_OUT) else $error("tx leak");
  tx_off_a: assert property (!TX_SQUELCH_OK [*8] ##1 !TX_SQUELCH_OK [*7] |-> !TX_DRIVER_ON) else $error("tx on");
  // one of the two pin samples behind the filter decision was above squelch
  tx_start_a: assert property ($rose(TX_DRIVER_ON) |-> $past(TX_SQUELCH_OK, 5) || $past(TX_SQUELCH_OK, 6))
    else $error("tx start");
  rx_squelch_a: assert property (!RX_DC_ABOVE [*6] |-> !RX_ACTIVE) else $error("rx on");
  aui_down_a: assert property (!RX_TERMINATED [*7] |-> !AUI_POWERED) else $error("aui up");
  aui_tx_a: assert property (!AUI_POWERED [*3] |-> !TX_DRIVER_ON) else $error("tx no aui");
  coll_gap_a: assert property ($fell(COLLISION_OUT_PAIR) |=> !COLLISION_OUT_PAIR) else $error("coll gap");
  jab_limit_a: assert property (on_run <= JABBER_CYC + 8) else $error("jabber late");
endmodule : coax_mau_checker

// ---- bench/station_model.sv ----
// station model driving the transmit pair
`timescale 1ns/100ps
module station_model (
  input wire logic       clk,      // clock
  input wire logic       go,       // start a frame
  input wire logic [9:0] len,      // frame cycles
  output logic           tx_data,  // transmit data
  output logic           tx_ok,    // above squelch
  output logic           busy      // frame running
);
  logic [9:0] left = 10'h000;
  logic       ph   = 1'b0;
  initial begin
    tx_data = 1'b0;
    tx_ok = 1'b0;
    busy = 1'b0;
  end
  always @(posedge clk) begin
    ph <= ~ph;
    if (ph) begin
      tx_data <= ~tx_data;  // half-bit of two cycles, never parked at one level
    end
    if (go && !busy) begin
      left <= len;
      busy <= 1'b1;
      tx_ok <= 1'b1;
    end else if (left > 10'h001) begin
      left <= left - 10'h001;
    end else begin
      busy <= 1'b0;
      tx_ok <= 1'b0;  // amplitude drops at frame end
    end
  end
endmodule : station_model

// ---- bench/tb.sv ----
// self-checking bench for the coax attachment control logic
`timescale 1ns/100ps
module tb;
  logic CLOCK = 1'b0, RSTN = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, go = 1'b0, HEARTBEAT_STRAP = 1'b1;
  logic COAX_RECEIVE_IN = 1'b0, RX_DC_ABOVE = 1'b0, COLL_RX_CMP = 1'b0, COLL_TX_CMP = 1'b0, RX_TERMINATED = 1'b0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, rd;
  logic [1:0]  HTRANS = 2'h0;
  logic [9:0]  len = 10'h0;
  wire logic [31:0] HRDATA;
  wire logic        HREADYOUT, HRESP, TX_DATA, TX_SQUELCH_OK, COAX_TRANSMIT_OUT, TX_DRIVER_ON, RX_OUT, RX_ACTIVE;
  wire logic        COLLISION_OUT_PAIR, AUI_POWERED, IRQ, busy;
  wire logic [3:0]  mon = {HREADYOUT, busy, AUI_POWERED, TX_DRIVER_ON};
  int mismatches = 0, samples_checked = 0, waited, cc, cr, ct;
  coax_mau_control_logic #(.JABBER_CYC(200), .JAB_IDLE_CYC(300), .ISOLATE_CYC(400)) dut (
    .HSIZE(3'h2), .HREADY(HREADYOUT), .*);
  station_model partner (.clk(CLOCK), .go(go), .len(len), .tx_data(TX_DATA), .tx_ok(TX_SQUELCH_OK), .busy(busy));
  initial forever #12.5 CLOCK = ~CLOCK;
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wt(input int b, input logic v);
    waited = 0;
    while (mon[b] !== v && waited < 2000) begin
      @(posedge CLOCK);
      waited++;
    end
    if (waited >= 2000) begin
      mismatches++;
      print_verdict;
    end
  endtask : wt
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    HSEL <= 1'b1;
    HADDR <= {24'h0, a};
    HTRANS <= 2'b10;
    HWRITE <= w;
    @(posedge CLOCK);
    wt(3, 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= wd;
    @(posedge CLOCK);
    wt(3, 1'b1);
    rd = HRDATA;
  endtask : bus
  task frame(input logic [9:0] l);
    len <= l;
    go <= 1'b1;
    @(posedge CLOCK);
    go <= 1'b0;
    @(posedge CLOCK);
  endtask : frame
  task obs(input int k);
    cc = 0;
    cr = 0;
    ct = 0;
    for (int i = 0; i < k; i++) begin
      @(posedge CLOCK);
      if (i[0]) begin
        COAX_RECEIVE_IN <= ~COAX_RECEIVE_IN;
      end
      cc += int'(COLLISION_OUT_PAIR !== 1'b0);
      cr += int'(RX_OUT !== 1'b0);
      ct += int'(COAX_TRANSMIT_OUT !== 1'b0);
    end
  endtask : obs
  task t_regs;
    chk(32'(AUI_POWERED), 32'h0);
    bus(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h7);
    chk(32'({HREADYOUT, HRESP}), 32'h2);
    bus(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    RX_TERMINATED <= 1'b1;
    wt(1, 1'b1);
    $display("regs done");
  endtask : t_regs
  task t_tx;
    bus(1'b1, 8'h08, 32'h3f);
    bus(1'b1, 8'h0c, 32'h08);
    repeat (2) @(posedge CLOCK);
    chk(32'(IRQ), 32'h0);
    frame(10'd40);
    wt(0, 1'b1);
    obs(30);
    chk(32'(ct inside {[12:18]}), 32'h1);
    wt(2, 1'b0);
    wt(0, 1'b0);
    chk(32'(waited inside {[9:15]}), 32'h1);
    obs(150);
    chk(32'(cc inside {[15:25]}), 32'h1);
    chk(32'(IRQ), 32'h1);
    bus(1'b0, 8'h08, 32'h0);
    chk(rd & 32'h8, 32'h8);
    bus(1'b1, 8'h08, 32'h8);
    repeat (2) @(posedge CLOCK);
    chk(32'(IRQ), 32'h0);
    bus(1'b1, 8'h0c, 32'h0);
    HEARTBEAT_STRAP <= 1'b0;
    frame(10'd40);
    wt(2, 1'b0);
    obs(150);
    chk(32'(cc), 32'h0);
    HEARTBEAT_STRAP <= 1'b1;
    $display("tx done");
  endtask : t_tx
  task t_rx;
    RX_DC_ABOVE <= 1'b1;
    obs(40);
    chk(32'(RX_ACTIVE), 32'h1);
    chk(32'(cr inside {[12:25]}), 32'h1);
    bus(1'b1, 8'h00, 32'h5);
    obs(4);
    obs(20);
    chk(32'(cr), 32'h0);
    chk(32'(RX_ACTIVE), 32'h0);
    bus(1'b1, 8'h00, 32'h7);
    RX_DC_ABOVE <= 1'b0;
    obs(10);
    obs(30);
    chk(32'(cr), 32'h0);
    $display("rx done");
  endtask : t_rx
  task t_coll;
    COLL_TX_CMP <= 1'b1;
    obs(40);
    chk(32'(cc), 32'h0);
    COLL_TX_CMP <= 1'b0;
    COLL_RX_CMP <= 1'b1;
    obs(40);
    chk(32'(cc inside {[8:25]}), 32'h1);
    COLL_RX_CMP <= 1'b0;
    obs(20);
    frame(10'd80);
    COLL_TX_CMP <= 1'b1;
    obs(40);
    chk(32'(cc > 5), 32'h1);
    COLL_TX_CMP <= 1'b0;
    wt(2, 1'b0);
    obs(200);
    $display("coll done");
  endtask : t_coll
  task t_jab;
    frame(10'd600);
    obs(300);
    chk(32'(TX_DRIVER_ON), 32'h0);
    chk(32'(cc > 20), 32'h1);
    wt(2, 1'b0);
    obs(250);
    bus(1'b0, 8'h04, 32'h0);
    chk(rd & 32'h2, 32'h2);
    obs(100);
    bus(1'b0, 8'h04, 32'h0);
    chk(rd & 32'h2, 32'h0);
    $display("jabber done");
  endtask : t_jab
  task t_iso;
    RX_TERMINATED <= 1'b0;
    obs(8);
    chk(32'(AUI_POWERED), 32'h0);
    obs(300);
    chk(32'(cc > 50), 32'h1);
    obs(120);
    obs(60);
    chk(32'(cc), 32'h0);
    $display("iso done");
  endtask : t_iso
  initial begin
    repeat (16) @(posedge CLOCK);
    RSTN <= 1'b1;
    repeat (3) @(posedge CLOCK);
    t_regs;
    t_tx;
    t_rx;
    t_coll;
    t_jab;
    t_iso;
    print_verdict;
  end
endmodule : tb
bind coax_mau_control_logic coax_mau_checker #(.JABBER_CYC(JABBER_CYC)) pin_chk (.*);
